//--- design/rce_pkg.sv
package rce_pkg;

  // ==========================================================================
  // Relay space
  localparam int RELAY_W = 6;
  localparam int RELAY_COUNT = 48;
  localparam int GROUP_SIZE = 8;
  localparam logic [RELAY_W-1:0] BASE_OUT = 6'h00;
  localparam logic [RELAY_W-1:0] BASE_MARK = 6'h08;
  localparam logic [RELAY_W-1:0] BASE_TEXT = 6'h18;
  localparam logic [RELAY_W-1:0] BASE_EXP = 6'h20;
  localparam logic [RELAY_W-1:0] BASE_JUMP = 6'h28;
  localparam logic [RELAY_W-1:0] BASE_FUNC = 6'h30;
  localparam logic [RELAY_W-1:0] RELAY_LIMIT = 6'h30;

  // ==========================================================================
  // Coil functions
  localparam logic [1:0] COIL_CONTACTOR = 2'h0;
  localparam logic [1:0] COIL_IMPULSE = 2'h1;
  localparam logic [1:0] COIL_LATCH = 2'h2;
  localparam logic [1:0] COIL_UNLATCH = 2'h3;

  // ==========================================================================
  // Coil instance memory
  localparam int SLOT_W = 6;
  localparam int SLOT_COUNT = 64;

  // ==========================================================================
  // Function relays
  localparam int FR_COUNT = 8;
  localparam int FR_W = 14;
  localparam logic [FR_W-1:0] FR_MAX = 14'h270F;
  localparam logic [FR_W-1:0] FR_STEP = 14'h0001;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RET_LO = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RET_HI = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FR_RET = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATE_LO = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATE_HI = 8'h14;
  localparam logic [ADDR_W-1:0] REG_FR_CONTACT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SETPOINT = 8'h20;
  localparam logic [ADDR_W-1:0] REG_ACTUAL = 8'h40;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 8'hE0;
  localparam int IDX_LSB = 2;
  localparam int CTRL_EXP_BIT = 0;
  localparam int RET_HI_W = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage : rce_pkg

//--- design/rce_edge_mem.sv
`timescale 1ns/100ps
`default_nettype none
module rce_edge_mem (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [rce_pkg::SLOT_W-1:0] wr_addr,
  input wire logic wr_data,
  input wire logic [rce_pkg::SLOT_W-1:0] rd_addr,
  output logic rd_data
);

  logic [rce_pkg::SLOT_COUNT-1:0] bits_reg;

  // ==========================================================================
  // Previous rung of each coil instance
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bits_reg <= '0;
    end else if (clear) begin
      bits_reg <= '0; // Edge history forgotten with the relays
    end else if (wr_en) begin
      bits_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 1'b0;
    end else begin
      rd_data <= clear ? 1'b0 : bits_reg[rd_addr];
    end
  end

endmodule : rce_edge_mem
`default_nettype wire

//--- design/rce_coil_logic.sv
`timescale 1ns/100ps
`default_nettype none
module rce_coil_logic (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run_mode,
  input wire logic power_fail,
  input wire logic coil_valid,
  input wire logic [rce_pkg::RELAY_W-1:0] coil_relay,
  input wire logic [1:0] coil_func,
  input wire logic [rce_pkg::SLOT_W-1:0] coil_slot,
  input wire logic coil_rung,
  input wire logic [rce_pkg::FR_COUNT-1:0] counter_count_coil,
  input wire logic [rce_pkg::FR_COUNT-1:0] counter_clear_coil,
  input wire logic [rce_pkg::FR_COUNT-1:0] fr_param_start,
  input wire logic [rce_pkg::RELAY_W-1:0] contact_sel,
  input wire logic contact_break,
  output logic contact_level,
  output logic [rce_pkg::GROUP_SIZE-1:0] out_terminal,
  output logic [rce_pkg::GROUP_SIZE-1:0] exp_terminal,
  output logic [rce_pkg::GROUP_SIZE-1:0] text_relay,
  output logic [rce_pkg::GROUP_SIZE-1:0] jump_relay,
  input wire logic [rce_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ==========================================================================
  // Declarations
  logic [rce_pkg::RELAY_COUNT-1:0] relay_state_reg;
  logic [31:0] ret_lo_reg;
  logic [rce_pkg::RET_HI_W-1:0] ret_hi_reg;
  logic [rce_pkg::FR_COUNT-1:0] fr_ret_reg;
  logic exp_present_reg;
  logic s1_valid_reg;
  logic [rce_pkg::RELAY_W-1:0] s1_relay_reg;
  logic [1:0] s1_func_reg;
  logic [rce_pkg::SLOT_W-1:0] s1_slot_reg;
  logic s1_rung_reg;
  logic byp_reg;
  logic byp_val_reg;
  logic mem_prev;
  logic prev_rung;
  logic clear_cond;
  logic apply;
  logic [rce_pkg::RELAY_COUNT-1:0] ret_mask;
  logic [rce_pkg::FR_W-1:0] setpoint_reg [rce_pkg::FR_COUNT];
  logic [rce_pkg::FR_W-1:0] actual_reg [rce_pkg::FR_COUNT];
  logic [rce_pkg::FR_COUNT-1:0] start_prev_reg;
  logic [rce_pkg::FR_COUNT-1:0] fr_contact;
  logic [rce_pkg::RELAY_COUNT+rce_pkg::FR_COUNT-1:0] contact_space;

  // ==========================================================================
  // Functions
  function automatic logic coil_next(input logic [1:0] func, input logic cur,
                                     input logic rung, input logic prev);
    logic result;
    result = cur;
    unique case (func)
      rce_pkg::COIL_CONTACTOR: result = rung;
      rce_pkg::COIL_IMPULSE: result = (rung && !prev) ? !cur : cur;
      rce_pkg::COIL_LATCH: result = rung ? 1'b1 : cur;
      rce_pkg::COIL_UNLATCH: result = rung ? 1'b0 : cur;
    endcase
    return result;
  endfunction : coil_next

  function automatic logic in_block(input logic [rce_pkg::ADDR_W-1:0] addr,
                                    input logic [rce_pkg::ADDR_W-1:0] base);
    return (addr & rce_pkg::BLOCK_MASK) == base;
  endfunction : in_block

  // ==========================================================================
  // Mode and qualifiers
  assign clear_cond = power_fail || !run_mode;
  assign ret_mask = {ret_hi_reg, ret_lo_reg};
  assign apply = s1_valid_reg && !clear_cond && (s1_relay_reg < rce_pkg::RELAY_LIMIT);
  assign prev_rung = byp_reg ? byp_val_reg : mem_prev;

  // Coil stage: one coil per cycle in diagram order, skipped coils never arrive
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_valid_reg <= 1'b0;
      s1_relay_reg <= '0;
      s1_func_reg <= rce_pkg::COIL_CONTACTOR;
      s1_slot_reg <= '0;
      s1_rung_reg <= 1'b0;
    end else begin
      s1_valid_reg <= coil_valid;
      s1_relay_reg <= coil_relay;
      s1_func_reg <= coil_func;
      s1_slot_reg <= coil_slot;
      s1_rung_reg <= coil_rung;
    end
  end

  // Bypass when the same instance is re-evaluated in the next cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byp_reg <= 1'b0;
      byp_val_reg <= 1'b0;
    end else begin
      byp_reg <= !clear_cond && s1_valid_reg && coil_valid && (s1_slot_reg == coil_slot);
      byp_val_reg <= s1_rung_reg;
    end
  end

  // Per-instance rung history
  rce_edge_mem u_edge_mem (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(clear_cond),
    .wr_en(s1_valid_reg && !clear_cond),
    .wr_addr(s1_slot_reg),
    .wr_data(s1_rung_reg),
    .rd_addr(coil_slot),
    .rd_data(mem_prev)
  );

  // ==========================================================================
  // Relay state: each coil writes in turn, so the last one wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      relay_state_reg <= '0;
    end else if (clear_cond) begin
      relay_state_reg <= relay_state_reg & ret_mask;
    end else if (apply) begin
      relay_state_reg[s1_relay_reg] <= coil_next(s1_func_reg, relay_state_reg[s1_relay_reg],
                                                 s1_rung_reg, prev_rung);
    end
  end

  // Terminals; expansion relays stay internal markers without a unit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_terminal <= '0;
      exp_terminal <= '0;
      text_relay <= '0;
      jump_relay <= '0;
    end else begin
      out_terminal <= relay_state_reg[rce_pkg::BASE_OUT +: rce_pkg::GROUP_SIZE];
      exp_terminal <= exp_present_reg ?
                      relay_state_reg[rce_pkg::BASE_EXP +: rce_pkg::GROUP_SIZE] : '0;
      text_relay <= relay_state_reg[rce_pkg::BASE_TEXT +: rce_pkg::GROUP_SIZE];
      jump_relay <= relay_state_reg[rce_pkg::BASE_JUMP +: rce_pkg::GROUP_SIZE];
    end
  end

  // ==========================================================================
  // Function relays: started by coil or parameter, contact at setpoint
  generate
    for (genvar i = 0; i < rce_pkg::FR_COUNT; i++) begin : g_fr
      logic start;
      assign start = counter_count_coil[i] || fr_param_start[i];
      assign fr_contact[i] = actual_reg[i] >= setpoint_reg[i];

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          actual_reg[i] <= '0;
          start_prev_reg[i] <= 1'b0;
        end else if (clear_cond) begin
          start_prev_reg[i] <= 1'b0;
          if (!fr_ret_reg[i]) begin
            actual_reg[i] <= '0;
          end
        end else begin
          start_prev_reg[i] <= start;
          if (counter_clear_coil[i]) begin
            actual_reg[i] <= '0;
          end else if (start && !start_prev_reg[i] && actual_reg[i] < rce_pkg::FR_MAX) begin
            actual_reg[i] <= actual_reg[i] + rce_pkg::FR_STEP;
          end
        end
      end

      fr_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clear_cond && !fr_ret_reg[i] |=> actual_reg[i] == '0)
        else $error("function relay value kept through stop");
    end
  endgenerate

  // ==========================================================================
  // Contact read: normally open passes state, normally closed its inverse
  assign contact_space = {fr_contact, relay_state_reg};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      contact_level <= 1'b0;
    end else begin
      contact_level <= contact_space[contact_sel] ^ contact_break;
    end
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      exp_present_reg <= 1'b0;
      ret_lo_reg <= rce_pkg::RESET_WORD;
      ret_hi_reg <= '0;
      fr_ret_reg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == rce_pkg::REG_CTRL) begin
        exp_present_reg <= reg_wdata[rce_pkg::CTRL_EXP_BIT];
      end
      if (reg_addr == rce_pkg::REG_RET_LO) begin
        ret_lo_reg <= reg_wdata;
      end
      if (reg_addr == rce_pkg::REG_RET_HI) begin
        ret_hi_reg <= reg_wdata[rce_pkg::RET_HI_W-1:0];
      end
      if (reg_addr == rce_pkg::REG_FR_RET) begin
        fr_ret_reg <= reg_wdata[rce_pkg::FR_COUNT-1:0];
      end
    end
  end

  // Setpoints, one word each
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < rce_pkg::FR_COUNT; k++) begin
        setpoint_reg[k] <= '0;
      end
    end else if (reg_wr && in_block(reg_addr, rce_pkg::REG_SETPOINT)) begin
      setpoint_reg[reg_addr[rce_pkg::IDX_LSB +: 3]] <= reg_wdata[rce_pkg::FR_W-1:0];
    end
  end

  // Read data valid in the cycle after the strobe only, unmapped reads zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= rce_pkg::RESET_WORD;
    end else if (!reg_rd) begin
      reg_rdata <= rce_pkg::RESET_WORD;
    end else if (in_block(reg_addr, rce_pkg::REG_SETPOINT)) begin
      reg_rdata <= {18'h00000, setpoint_reg[reg_addr[rce_pkg::IDX_LSB +: 3]]};
    end else if (in_block(reg_addr, rce_pkg::REG_ACTUAL)) begin
      reg_rdata <= {18'h00000, actual_reg[reg_addr[rce_pkg::IDX_LSB +: 3]]};
    end else begin
      unique case (reg_addr)
        rce_pkg::REG_CTRL: reg_rdata <= {31'h00000000, exp_present_reg};
        rce_pkg::REG_RET_LO: reg_rdata <= ret_lo_reg;
        rce_pkg::REG_RET_HI: reg_rdata <= {16'h0000, ret_hi_reg};
        rce_pkg::REG_FR_RET: reg_rdata <= {24'h000000, fr_ret_reg};
        rce_pkg::REG_STATE_LO: reg_rdata <= relay_state_reg[31:0];
        rce_pkg::REG_STATE_HI: reg_rdata <= {16'h0000, relay_state_reg[47:32]};
        rce_pkg::REG_FR_CONTACT: reg_rdata <= {24'h000000, fr_contact};
        default: reg_rdata <= rce_pkg::RESET_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  contactor_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    apply && s1_func_reg == rce_pkg::COIL_CONTACTOR
    |=> relay_state_reg[$past(s1_relay_reg)] == $past(s1_rung_reg))
    else $error("contactor relay did not follow rung");

  impulse_toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    apply && s1_func_reg == rce_pkg::COIL_IMPULSE && s1_rung_reg && !prev_rung
    |=> relay_state_reg[$past(s1_relay_reg)] != $past(relay_state_reg[s1_relay_reg]))
    else $error("impulse relay did not toggle");

  impulse_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    apply && s1_func_reg == rce_pkg::COIL_IMPULSE && !(s1_rung_reg && !prev_rung)
    |=> $stable(relay_state_reg))
    else $error("impulse relay changed without rising rung");

  latch_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    apply && s1_func_reg == rce_pkg::COIL_LATCH && s1_rung_reg
    |=> relay_state_reg[$past(s1_relay_reg)])
    else $error("latch coil did not set relay");

  unlatch_last_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    apply && s1_func_reg == rce_pkg::COIL_UNLATCH && s1_rung_reg
    |=> !relay_state_reg[$past(s1_relay_reg)])
    else $error("later unlatch coil did not win");

  stop_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clear_cond |=> (relay_state_reg & ~$past(ret_mask)) == '0)
    else $error("relay survived stop or power loss");

  retain_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clear_cond |=> (relay_state_reg & $past(ret_mask)) == $past(relay_state_reg & ret_mask))
    else $error("retentive relay lost its state");

  output_map_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> out_terminal == $past(relay_state_reg[7:0]))
    else $error("output terminal does not show relay");

  exp_internal_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !exp_present_reg |=> exp_terminal == '0)
    else $error("expansion terminal driven without unit");

  contact_sense_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    contact_sel < rce_pkg::RELAY_LIMIT && contact_break
    |=> contact_level == !$past(relay_state_reg[contact_sel]))
    else $error("break contact not inverted");

endmodule : rce_coil_logic
`default_nettype wire

//--- testbench/rce_scan_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Ladder scan evaluator: hands over one rung result per coil
module rce_scan_model (
  input wire logic sys_clk,
  output logic coil_valid,
  output logic [rce_pkg::RELAY_W-1:0] coil_relay,
  output logic [1:0] coil_func,
  output logic [rce_pkg::SLOT_W-1:0] coil_slot,
  output logic coil_rung
);
  bit held = 1'b0;

  // Idle lines start inverted so no stale coil looks live
  initial begin
    coil_valid = 1'b0;
    coil_relay = 6'h3F;
    coil_func = 2'h3;
    coil_slot = 6'h3F;
    coil_rung = 1'b0;
  end

  // Sends one coil; more keeps valid up for a back-to-back successor
  task send(input logic [5:0] r, input logic [1:0] f, input logic [5:0] s,
            input logic g, input logic more, input int gap);
    if (!held) repeat (gap + 1) @(posedge sys_clk);
    coil_valid <= 1'b1;
    coil_relay <= r;
    coil_func <= f;
    coil_slot <= s;
    coil_rung <= g;
    @(posedge sys_clk);
    held = more;
    if (!more) begin
      coil_valid <= 1'b0;
      coil_relay <= ~r;
      coil_func <= ~f;
      coil_slot <= ~s;
      coil_rung <= ~g;
    end
  endtask : send
endmodule : rce_scan_model
`default_nettype wire

//--- testbench/relay_coil_function_logic_bench.sv
`timescale 1ns/100ps
`default_nettype none
module relay_coil_function_logic_bench;
  // ============================================================
  // Design signals
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic run_mode = 1'b0;
  logic power_fail = 1'b0;
  logic coil_valid, coil_rung, contact_level;
  logic [5:0] coil_relay, coil_slot;
  logic [1:0] coil_func;
  logic [7:0] counter_count_coil = 8'h00;
  logic [7:0] counter_clear_coil = 8'h00;
  logic [7:0] fr_param_start = 8'h00;
  logic [5:0] contact_sel = 6'h00;
  logic contact_break = 1'b0;
  logic [7:0] out_terminal, exp_terminal, text_relay, jump_relay;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  int n_mismatch = 0;
  int tests_run = 0;
  // Reference model state
  logic [31:0] seed = 32'h0000_C98F;
  logic [47:0] m_state = 48'h0000_0000_0000;
  logic [47:0] m_ret;
  logic [63:0] m_prev = 64'h0;
  logic m_exp = 1'b0;
  logic m_run = 1'b0;
  int m_act[8];
  int m_set[8];

  // Clock
  always #10 sys_clk = ~sys_clk;

  rce_scan_model u_scan (.sys_clk, .coil_valid, .coil_relay, .coil_func, .coil_slot,
    .coil_rung);
  rce_coil_logic DUT (.sys_clk, .resetn, .run_mode, .power_fail, .coil_valid, .coil_relay,
    .coil_func, .coil_slot, .coil_rung, .counter_count_coil, .counter_clear_coil,
    .fr_param_start, .contact_sel, .contact_break, .contact_level, .out_terminal,
    .exp_terminal, .text_relay, .jump_relay, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  // ============================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 chk(what, exp, reg_rdata);
  endtask : rdchk

  // Sends a coil and applies it to the model in diagram order
  task put_coil(input int r, input int f, input int s, input logic g, input logic more,
                input int gap);
    u_scan.send(6'(r), 2'(f), 6'(s), g, more, gap);
    if (!m_run || r >= 48) return;
    case (f)
      0: m_state[r] = g;
      1: begin
        if (g && !m_prev[s]) m_state[r] = ~m_state[r];
        m_prev[s] = g;
      end
      2: if (g) m_state[r] = 1'b1;
      default: if (g) m_state[r] = 1'b0;
    endcase
  endtask : put_coil

  // Random coil; impulse coils own slots 32 to 63
  task coil_rand(input logic more);
    logic [31:0] x;
    int r;
    int f;
    x = rnd();
    f = int'(x[1:0]);
    r = x[2] ? x[7:3] % 12 : x[13:8] % 52;
    if (f == 1) r = r % 48;
    put_coil(r, f, (f == 1) ? 32 + x[20:16] : int'(x[20:16]), x[24], more, x[27:26]);
  endtask : coil_rand

  task check_all();
    logic [31:0] x;
    int c;
    rdchk(rce_pkg::REG_STATE_LO, m_state[31:0], "state_lo");
    rdchk(rce_pkg::REG_STATE_HI, 32'(m_state[47:32]), "state_hi");
    chk("out_terminal", 32'(m_state[7:0]), 32'(out_terminal));
    chk("exp_terminal", m_exp ? 32'(m_state[39:32]) : 32'h0, 32'(exp_terminal));
    chk("text_relay", 32'(m_state[31:24]), 32'(text_relay));
    chk("jump_relay", 32'(m_state[47:40]), 32'(jump_relay));
    x = rnd();
    c = x[5:0] % 48;
    @(posedge sys_clk);
    contact_sel <= 6'(c);
    contact_break <= x[8];
    @(posedge sys_clk);
    #1 chk("contact_level", 32'(m_state[c] ^ x[8]), 32'(contact_level));
  endtask : check_all

  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] x;
    logic [7:0] fc;
    for (int i = 0; i < 8; i++) begin
      m_act[i] = 0;
      m_set[i] = 0;
    end
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(rce_pkg::REG_CTRL, 32'h0, "ctrl");
    rdchk(rce_pkg::REG_RET_LO, 32'h0, "ret_lo");
    rdchk(rce_pkg::REG_STATE_LO, 32'h0, "state_lo");
    rdchk(8'hFC, 32'h0, "unmapped");
    chk("out_terminal", 32'h0, 32'(out_terminal));
    $display("test reset done");
    @(posedge sys_clk);
    run_mode <= 1'b1;
    m_run = 1'b1;
    wr(8'hFC, 32'hFFFF_FFFF);
    for (int k = 0; k < 2; k++) begin
      put_coil(5, 2 + k, 1, 1'b1, 1'b1, 0);
      put_coil(5, 3 - k, 2, 1'b1, 1'b0, 0);
      put_coil(9, 0, 3, 1'b1, 1'b1, 0);
      put_coil(9, 0, 4, k[0], 1'b0, 0);
      check_all();
    end
    $display("test coil order done");
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        wr(rce_pkg::REG_CTRL, 32'h0000_0001);
        m_exp = 1'b1;
        rdchk(rce_pkg::REG_CTRL, 32'h0000_0001, "ctrl");
      end
      repeat (15) begin
        coil_rand(1'b1);
        coil_rand(1'b0);
        check_all();
      end
      x = rnd();
      m_ret = {x[15:0], rnd()};
      wr(rce_pkg::REG_RET_LO, m_ret[31:0]);
      wr(rce_pkg::REG_RET_HI, 32'(m_ret[47:32]));
      rdchk(rce_pkg::REG_RET_HI, 32'(m_ret[47:32]), "ret_hi");
      rdchk(rce_pkg::REG_RET_LO, m_ret[31:0], "ret_lo");
      @(posedge sys_clk);
      if (k[0]) power_fail <= 1'b1;
      else run_mode <= 1'b0;
      m_run = 1'b0;
      m_state &= m_ret;
      m_prev = 64'h0;
      coil_rand(1'b0);
      check_all();
      @(posedge sys_clk);
      power_fail <= 1'b0;
      run_mode <= 1'b1;
      m_run = 1'b1;
      $display("test clear pass %0d done", k);
    end
    for (int i = 0; i < 8; i++) begin
      x = rnd();
      m_set[i] = 1 + x[1:0];
      wr(8'(rce_pkg::REG_SETPOINT + 4 * i), 32'(m_set[i]));
      rdchk(8'(rce_pkg::REG_SETPOINT + 4 * i), 32'(m_set[i]), "setpoint");
      for (int j = 0; j < x[4:2] % 6; j++) begin
        @(posedge sys_clk);
        if (j % 2 == 1) fr_param_start[i] <= 1'b1;
        else counter_count_coil[i] <= 1'b1;
        @(posedge sys_clk);
        fr_param_start <= 8'h00;
        counter_count_coil <= 8'h00;
        m_act[i]++;
      end
      wr(8'(rce_pkg::REG_ACTUAL + 4 * i), 32'h0000_00FF);
      rdchk(8'(rce_pkg::REG_ACTUAL + 4 * i), 32'(m_act[i]), "actual");
      @(posedge sys_clk);
      contact_sel <= 6'(48 + i);
      contact_break <= x[9];
      @(posedge sys_clk);
      #1 chk("fr_contact", 32'((m_act[i] >= m_set[i]) ^ x[9]), 32'(contact_level));
      fc[i] = m_act[i] >= m_set[i];
    end
    rdchk(rce_pkg::REG_FR_CONTACT, 32'(fc), "fr_contacts");
    x = rnd();
    wr(rce_pkg::REG_FR_RET, 32'(x[7:0]));
    rdchk(rce_pkg::REG_FR_RET, 32'(x[7:0]), "fr_ret");
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      if (p == 0) power_fail <= 1'b1;
      else counter_clear_coil <= 8'hFF;
      repeat (2) @(posedge sys_clk);
      power_fail <= 1'b0;
      counter_clear_coil <= 8'h00;
      if (p == 0) m_state &= m_ret;
      for (int i = 0; i < 8; i++) begin
        if (p == 1 || !x[i]) m_act[i] = 0;
        rdchk(8'(rce_pkg::REG_ACTUAL + 4 * i), 32'(m_act[i]), "actual_clear");
      end
    end
    check_all();
    $display("test function relays done");
    test_done();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
endmodule : relay_coil_function_logic_bench
`default_nettype wire
